// ==== rtl/uwm_pkg.sv ====
`default_nettype none
package uwm_pkg;
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] ADDR_MODE = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_CTL1 = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_CTL2 = 8'h0c;
	localparam logic [ADDR_W-1:0] ADDR_DATA = 8'h10;
	localparam logic [ADDR_W-1:0] ADDR_BAUD = 8'h14;
	localparam logic [7:0] MODE_RESET = 8'he0;
	localparam logic [7:0] CTL1_RESET = 8'h00;
	localparam logic [7:0] CTL2_RESET = 8'h00;
	localparam logic [7:0] BAUD_RESET = 8'h00;
	localparam logic [7:0] STAT_RESET = 8'h0b;
	localparam logic [2:0] SUBMODE_OFF = 3'h0;
	localparam logic [23:0] RDATA_PAD = 24'h000000;
	// Sub-ticks per bit minus one: 15 in high-speed mode, 63 otherwise
	localparam logic [6:0] SUB_TOP_HIGH = 7'h0f;
	localparam logic [6:0] SUB_TOP_LOW = 7'h3f;
	localparam logic [3:0] LAST_BIT_NINE = 4'h8;
	localparam logic [3:0] LAST_BIT_EIGHT = 4'h7;
	localparam logic [3:0] FIRST_STOP = 4'h0;
	localparam logic [3:0] SECOND_STOP = 4'h1;

	typedef struct packed {
		logic [2:0] submode;
		logic asyncModeSelect;
		logic [1:0] debounce;
		logic syncEnable;
		logic incomplete;
	} uwm_mode_t;

	typedef struct packed {
		logic enable;
		logic nineBit;
		logic parityEn;
		logic parityOdd;
		logic twoStop;
		logic sendBreak;
		logic rxNinth;
		logic txNinth;
	} uwm_ctl1_t;

	typedef struct packed {
		logic txEn;
		logic rxEn;
		logic highSpeed;
		logic addrDetect;
		logic rxWake;
		logic rxIntEn;
		logic idleIntEn;
		logic emptyIntEn;
	} uwm_ctl2_t;

	typedef struct packed {
		logic parityErr;
		logic noise;
		logic framingErr;
		logic overrun;
		logic rxIdle;
		logic rxAvail;
		logic txIdle;
		logic txEmpty;
	} uwm_status_t;

	typedef struct packed {
		logic [8:0] data;
		logic parityErr;
		logic framingErr;
		logic noise;
	} uwm_rx_entry_t;

	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} uwm_tx_state_t;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} uwm_rx_state_t;
endpackage
`default_nettype wire

// ==== rtl/uwm_uart.sv ====
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
module uwm_uart
	import uwm_pkg::*;
#(
	parameter int RX_DEPTH = 2
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rxIn,
	output logic txOut,
	output logic txOe,
	input wire logic gpioTxPullup,
	input wire logic gpioRxPullup,
	output logic txPullupEn,
	output logic rxPullupEn,
	output logic serialIrq,
	output logic rxWakeReq,
	output logic [2:0] syncSubmode,
	output logic syncEnable
);
	localparam int PTR_W = (RX_DEPTH > 1) ? $clog2(RX_DEPTH) : 1;
	localparam int CNT_W = $clog2(RX_DEPTH + 1);
	localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(RX_DEPTH);

	////////////////////////////////////////////////////////////////////////
	function automatic logic [6:0] subTop(input logic highSpeed);
		subTop = highSpeed ? SUB_TOP_HIGH : SUB_TOP_LOW;
	endfunction

	function automatic logic majority3(input logic [2:0] v);
		majority3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
	endfunction

	function automatic logic [PTR_W-1:0] ptrInc(input logic [PTR_W-1:0] p);
		ptrInc = (p == PTR_W'(RX_DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	////////////////////////////////////////////////////////////////////////
	uwm_mode_t modeReg, modeNext;
	uwm_ctl1_t ctl1Reg, ctl1Next;
	uwm_ctl2_t ctl2Reg, ctl2Next;
	uwm_status_t statusVal;
	uwm_rx_entry_t rxFifo [RX_DEPTH];
	uwm_rx_entry_t rxHead, pushEntry;
	uwm_tx_state_t txStateReg, txStateNext;
	uwm_rx_state_t rxStateReg, rxStateNext;
	logic [7:0] baudReg, baudNext, preReg, preNext, readValue;
	logic [31:0] prdataReg, prdataNext;
	logic peReg, peNext, nfReg, nfNext, feReg, feNext, oeReg, oeNext;
	logic statSeenReg, statSeenNext, txHoldFullReg, txHoldFullNext;
	logic [8:0] txHoldReg, txHoldNext, txShiftReg, txShiftNext, rxShiftReg, rxShiftNext;
	logic [3:0] txBitReg, txBitNext, rxBitReg, rxBitNext, lastBit;
	logic [6:0] txSubReg, txSubNext, rxSubReg, rxSubNext, top, mid;
	logic txParReg, txParNext, txOutReg, txOutNext;
	logic rxParReg, rxParNext, rxPeReg, rxPeNext, rxNoiseReg, rxNoiseNext, rxPrevReg;
	logic [2:0] rxVoteReg, rxVoteNext;
	logic [PTR_W-1:0] rdPtrReg, rdPtrNext, wrPtrReg, wrPtrNext;
	logic [CNT_W-1:0] rxCntReg, rxCntNext;
	logic setupPhase, accessPhase, mapped, modeSel, active, tick, txBitDone, rxBitDone;
	logic pop, push, pushReq, pushFull, clearErr, bitVal, noisy, addrOk, txDrive;

	assign modeSel = modeReg.asyncModeSelect;
	assign active = modeSel && ctl1Reg.enable;
	assign setupPhase = psel && !penable;
	assign accessPhase = psel && penable;
	// Empty buffer reads zero rather than unwritten storage
	assign rxHead = (rxCntReg != '0) ? rxFifo[rdPtrReg] : '0;
	assign pready = 1'b1;
	assign pslverr = accessPhase && !mapped;
	assign prdata = prdataReg;

	////////////////////////////////////////////////////////////////////////
	// Register read mux; sampled in the setup phase so prdata is a flop
	always_comb begin
		statusVal.parityErr = peReg;
		statusVal.noise = nfReg;
		statusVal.framingErr = feReg;
		statusVal.overrun = oeReg;
		statusVal.rxIdle = (rxStateReg == RX_IDLE);
		statusVal.rxAvail = (rxCntReg != '0);
		statusVal.txIdle = !txHoldFullReg && (txStateReg == TX_IDLE);
		statusVal.txEmpty = !txHoldFullReg;
		readValue = 8'h00;
		mapped = 1'b1;
		case (paddr)
			ADDR_MODE: readValue = modeReg;
			ADDR_STAT: readValue = modeSel ? statusVal : 8'h00;
			ADDR_CTL1: readValue = modeSel ? {ctl1Reg[7:2], rxHead.data[8], 1'b0} : 8'h00;
			ADDR_CTL2: readValue = modeSel ? ctl2Reg : 8'h00;
			ADDR_DATA: readValue = modeSel ? rxHead.data[7:0] : 8'h00;
			ADDR_BAUD: readValue = modeSel ? baudReg : 8'h00;
			default: mapped = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		modeNext = modeReg;
		ctl1Next = ctl1Reg;
		ctl2Next = ctl2Reg;
		baudNext = baudReg;
		prdataNext = prdataReg;
		statSeenNext = statSeenReg;
		txHoldNext = txHoldReg;
		txHoldFullNext = txHoldFullReg;
		txStateNext = txStateReg;
		txShiftNext = txShiftReg;
		txBitNext = txBitReg;
		txSubNext = txSubReg;
		txParNext = txParReg;
		rxStateNext = rxStateReg;
		rxShiftNext = rxShiftReg;
		rxBitNext = rxBitReg;
		rxSubNext = rxSubReg;
		rxParNext = rxParReg;
		rxPeNext = rxPeReg;
		rxNoiseNext = rxNoiseReg;
		rxVoteNext = rxVoteReg;
		pop = 1'b0;
		pushReq = 1'b0;
		clearErr = 1'b0;
		top = subTop(ctl2Reg.highSpeed);
		mid = top >> 1;
		lastBit = ctl1Reg.nineBit ? LAST_BIT_NINE : LAST_BIT_EIGHT;
		if (setupPhase) begin
			prdataNext = {RDATA_PAD, readValue};
		end
		// Bus side effects land only at the access edge
		if (accessPhase && pwrite) begin
			if (paddr == ADDR_MODE) begin
				modeNext = pwdata[7:0];
			end
			if (modeSel && paddr == ADDR_CTL1) begin
				ctl1Next = pwdata[7:0];
				ctl1Next.rxNinth = 1'b0;
			end
			if (modeSel && paddr == ADDR_CTL2) begin
				ctl2Next = pwdata[7:0];
			end
			if (modeSel && paddr == ADDR_BAUD) begin
				baudNext = pwdata[7:0];
			end
			if (modeSel && paddr == ADDR_DATA) begin
				statSeenNext = 1'b0;
				// A write while the holding slot is full is dropped
				if (active && !txHoldFullReg) begin
					txHoldNext = {ctl1Reg.txNinth, pwdata[7:0]};
					txHoldFullNext = 1'b1;
				end
			end
		end
		if (accessPhase && !pwrite && modeSel) begin
			if (paddr == ADDR_STAT) begin
				statSeenNext = 1'b1;
			end
			if (paddr == ADDR_DATA) begin
				pop = (rxCntReg != '0);
				clearErr = statSeenReg;
				statSeenNext = 1'b0;
			end
		end
		// Shared prescaler: one tick every divisor plus one clocks
		tick = (preReg == baudReg);
		preNext = tick ? 8'h00 : preReg + 8'h01;
		txBitDone = tick && (txSubReg == top);
		rxBitDone = tick && (rxSubReg == top);
		if (tick) begin
			txSubNext = txBitDone ? 7'h00 : txSubReg + 7'h01;
			rxSubNext = rxBitDone ? 7'h00 : rxSubReg + 7'h01;
		end
		unique case (txStateReg)
			TX_IDLE: begin
				txSubNext = 7'h00;
				if (ctl2Reg.txEn && txHoldFullReg) begin
					txShiftNext = txHoldReg;
					txParNext = ^(ctl1Reg.nineBit ? txHoldReg : {1'b0, txHoldReg[7:0]})
						^ ctl1Reg.parityOdd;
					txHoldFullNext = 1'b0;
					txBitNext = 4'h0;
					txStateNext = TX_START;
				end
			end
			TX_START: if (txBitDone) begin
				txStateNext = TX_DATA;
			end
			TX_DATA: if (txBitDone) begin
				txShiftNext = txShiftReg >> 1;
				txBitNext = txBitReg + 4'h1;
				if (txBitReg == lastBit) begin
					txBitNext = FIRST_STOP;
					txStateNext = ctl1Reg.parityEn ? TX_PAR : TX_STOP;
				end
			end
			TX_PAR: if (txBitDone) begin
				txStateNext = TX_STOP;
			end
			TX_STOP: if (txBitDone) begin
				if (ctl1Reg.twoStop && txBitReg == FIRST_STOP) begin
					txBitNext = SECOND_STOP;
				end else begin
					txStateNext = TX_IDLE;
				end
			end
		endcase
		// Three votes around mid-bit; disagreement counts as noise
		if (tick && (rxSubReg == mid - 7'h01 || rxSubReg == mid || rxSubReg == mid + 7'h01)) begin
			rxVoteNext = {rxVoteReg[1:0], rxIn};
		end
		bitVal = majority3(rxVoteReg);
		noisy = (|rxVoteReg) && !(&rxVoteReg);
		if (rxBitDone) begin
			rxNoiseNext = rxNoiseReg | noisy;
		end
		unique case (rxStateReg)
			RX_IDLE: begin
				rxSubNext = 7'h00;
				if (ctl2Reg.rxEn && rxPrevReg && !rxIn) begin
					rxStateNext = RX_START;
					rxNoiseNext = 1'b0;
					rxParNext = 1'b0;
					rxPeNext = 1'b0;
					rxShiftNext = 9'h000;
					rxBitNext = 4'h0;
				end
			end
			RX_START: if (rxBitDone) begin
				// A high start sample is a glitch, not a frame
				rxStateNext = bitVal ? RX_IDLE : RX_DATA;
			end
			RX_DATA: if (rxBitDone) begin
				rxShiftNext[rxBitReg] = bitVal;
				rxParNext = rxParReg ^ bitVal;
				rxBitNext = rxBitReg + 4'h1;
				if (rxBitReg == lastBit) begin
					rxStateNext = ctl1Reg.parityEn ? RX_PAR : RX_STOP;
				end
			end
			RX_PAR: if (rxBitDone) begin
				rxPeNext = (rxParReg ^ bitVal) != ctl1Reg.parityOdd;
				rxStateNext = RX_STOP;
			end
			RX_STOP: if (rxBitDone) begin
				pushReq = 1'b1;
				rxStateNext = RX_IDLE;
			end
		endcase
		pushEntry.data = rxShiftReg;
		pushEntry.parityErr = rxPeReg;
		pushEntry.framingErr = !bitVal;
		pushEntry.noise = rxNoiseReg | noisy;
		addrOk = !ctl2Reg.addrDetect || (ctl1Reg.nineBit ? rxShiftReg[8] : rxShiftReg[7]);
		pushFull = pushReq && addrOk && (rxCntReg == CNT_FULL) && !pop;
		push = pushReq && addrOk && !pushFull;
		rdPtrNext = pop ? ptrInc(rdPtrReg) : rdPtrReg;
		wrPtrNext = push ? ptrInc(wrPtrReg) : wrPtrReg;
		rxCntNext = rxCntReg + CNT_W'(push) - CNT_W'(pop);
		// New errors win over a clearing read in the same cycle
		peNext = (push && pushEntry.parityErr) || (peReg && !clearErr);
		feNext = (push && pushEntry.framingErr) || (feReg && !clearErr);
		nfNext = (push && pushEntry.noise) || (nfReg && !clearErr);
		oeNext = pushFull || (oeReg && !clearErr);
		if (!active) begin
			preNext = 8'h00;
			txHoldFullNext = 1'b0;
			txStateNext = TX_IDLE;
			rxStateNext = RX_IDLE;
			txSubNext = 7'h00;
			rxSubNext = 7'h00;
			rdPtrNext = '0;
			wrPtrNext = '0;
			rxCntNext = '0;
			peNext = 1'b0;
			feNext = 1'b0;
			nfNext = 1'b0;
			oeNext = 1'b0;
			statSeenNext = 1'b0;
		end
		if (!ctl1Reg.enable) begin
			ctl2Next.txEn = 1'b0;
			ctl2Next.rxEn = 1'b0;
			ctl1Next.sendBreak = 1'b0;
		end
		txOutNext = 1'b1;
		unique case (txStateNext)
			TX_IDLE: txOutNext = !ctl1Reg.sendBreak;
			TX_START: txOutNext = 1'b0;
			TX_DATA: txOutNext = txShiftNext[0];
			TX_PAR: txOutNext = txParNext;
			TX_STOP: txOutNext = 1'b1;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			modeReg <= MODE_RESET;
			ctl1Reg <= CTL1_RESET;
			ctl2Reg <= CTL2_RESET;
			baudReg <= BAUD_RESET;
			prdataReg <= 32'h00000000;
			preReg <= 8'h00;
			peReg <= 1'b0;
			nfReg <= 1'b0;
			feReg <= 1'b0;
			oeReg <= 1'b0;
			statSeenReg <= 1'b0;
			txHoldReg <= 9'h000;
			txHoldFullReg <= 1'b0;
			txStateReg <= TX_IDLE;
			txShiftReg <= 9'h000;
			txBitReg <= 4'h0;
			txSubReg <= 7'h00;
			txParReg <= 1'b0;
			txOutReg <= 1'b1;
			rxStateReg <= RX_IDLE;
			rxShiftReg <= 9'h000;
			rxBitReg <= 4'h0;
			rxSubReg <= 7'h00;
			rxParReg <= 1'b0;
			rxPeReg <= 1'b0;
			rxNoiseReg <= 1'b0;
			rxVoteReg <= 3'h7;
			rxPrevReg <= 1'b1;
			rdPtrReg <= '0;
			wrPtrReg <= '0;
			rxCntReg <= '0;
		end else begin
			modeReg <= modeNext;
			ctl1Reg <= ctl1Next;
			ctl2Reg <= ctl2Next;
			baudReg <= baudNext;
			prdataReg <= prdataNext;
			preReg <= preNext;
			peReg <= peNext;
			nfReg <= nfNext;
			feReg <= feNext;
			oeReg <= oeNext;
			statSeenReg <= statSeenNext;
			txHoldReg <= txHoldNext;
			txHoldFullReg <= txHoldFullNext;
			txStateReg <= txStateNext;
			txShiftReg <= txShiftNext;
			txBitReg <= txBitNext;
			txSubReg <= txSubNext;
			txParReg <= txParNext;
			txOutReg <= txOutNext;
			rxStateReg <= rxStateNext;
			rxShiftReg <= rxShiftNext;
			rxBitReg <= rxBitNext;
			rxSubReg <= rxSubNext;
			rxParReg <= rxParNext;
			rxPeReg <= rxPeNext;
			rxNoiseReg <= rxNoiseNext;
			rxVoteReg <= rxVoteNext;
			rxPrevReg <= rxIn;
			rdPtrReg <= rdPtrNext;
			wrPtrReg <= wrPtrNext;
			rxCntReg <= rxCntNext;
		end
	end

	// Buffer storage is not reset; the count alone says what is valid
	always_ff @(posedge ref_clk) begin
		if (push) begin
			rxFifo[wrPtrReg] <= pushEntry;
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign txDrive = active && ctl2Reg.txEn;
	assign txOe = txDrive;
	assign txOut = txOutReg;
	assign txPullupEn = !txDrive && gpioTxPullup;
	assign rxPullupEn = gpioRxPullup;
	assign rxWakeReq = active && ctl2Reg.rxEn && ctl2Reg.rxWake && !rxIn;
	assign syncSubmode = modeSel ? SUBMODE_OFF : modeReg.submode;
	assign syncEnable = !modeSel && modeReg.syncEnable;
	// One request line from the receive, overrun, idle and empty sources, held low unless active
	assign serialIrq = active && ((ctl2Reg.rxIntEn && (statusVal.rxAvail || oeReg))
		|| (ctl2Reg.idleIntEn && statusVal.txIdle)
		|| (ctl2Reg.emptyIntEn && statusVal.txEmpty));

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);

	a_tx_pullup_off: assert property (txOe |-> !txPullupEn)
		else $error("TX pull-up on while TX driven");
	a_start_bit_low: assert property ($past(txStateReg) == TX_IDLE && txStateReg == TX_START
		|-> !txOutReg)
		else $error("Start bit not low");
	a_stop_bit_high: assert property (txStateReg == TX_STOP |-> txOutReg)
		else $error("Stop bit not high");
	a_fifo_bound: assert property (rxCntReg <= CNT_FULL)
		else $error("Receive buffer count above depth");
	a_overrun_flag: assert property (active && pushFull |=> oeReg && rxCntReg == CNT_FULL)
		else $error("Overrun not flagged");
	a_disable_clear: assert property (!ctl1Reg.enable |=> rxCntReg == '0 && !txHoldFullReg
		&& !oeReg && !ctl2Reg.txEn)
		else $error("Disable did not clear transceiver state");
	a_sync_gated: assert property (modeSel |-> !syncEnable && syncSubmode == SUBMODE_OFF)
		else $error("Sync serial controls active in transceiver mode");
	a_reg_hidden: assert property (setupPhase && !pwrite && !modeSel && paddr != ADDR_MODE
		|=> prdataReg == 32'h00000000)
		else $error("Transceiver register visible without mode select");
	a_tx_two_stop: assert property ($rose(txStateReg == TX_STOP) && ctl1Reg.twoStop
		&& ctl2Reg.highSpeed && baudReg == 8'h00 |-> txStateReg == TX_STOP [*8])
		else $error("Stop phase too short");

	c_tx_frame: cover property (txStateReg == TX_STOP ##1 txStateReg == TX_IDLE);
	c_rx_push: cover property (push);
	c_overrun: cover property (pushFull);
	c_parity_err: cover property (push && pushEntry.parityErr);
endmodule
`default_nettype wire

// ==== tb/uwm_serial_peer.sv ====
`timescale 1ns/100ps
`default_nettype none
// Far-end serial device; idles its line high and frames at a fixed bit time
module uwm_serial_peer #(
	parameter int BIT_CLKS = 16
) (
	input wire logic ref_clk,
	input wire logic txLine,
	output logic rxLine
);
	logic timedOut;

	initial begin
		rxLine = 1'b1;
		timedOut = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bits after the start bit, LSB first: data, parity, stops
	task automatic sendFrame(input logic [11:0] bits, input int n);
		int i;
		rxLine <= 1'b0;
		repeat (BIT_CLKS) @(posedge ref_clk);
		for (i = 0; i < n; i++) begin
			rxLine <= bits[i];
			repeat (BIT_CLKS) @(posedge ref_clk);
		end
		rxLine <= 1'b1;
	endtask

	// Samples at mid-bit so a one-tick phase slip of the start bit is tolerated
	task automatic recvFrame(input int n, output logic [11:0] bits);
		int i;
		bits = '1;
		for (i = 0; i < 400 && txLine !== 1'b0; i++) begin
			@(posedge ref_clk);
		end
		if (txLine !== 1'b0) begin
			timedOut = 1'b1;
			bits = 'x;
		end else begin
			repeat (BIT_CLKS / 2) @(posedge ref_clk);
			for (i = 0; i < n; i++) begin
				repeat (BIT_CLKS) @(posedge ref_clk);
				bits[i] = txLine;
			end
		end
	endtask
endmodule
`default_nettype wire

// ==== tb/uwm_uart_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module uwm_uart_tb
	import uwm_pkg::*;
;
	localparam int BIT = 16;
	logic ref_clk, reset_n, psel, penable, pwrite, pready, pslverr, lastErr;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata;
	logic rxIn, txOut, txOe, gpioTxPullup, gpioRxPullup, txPullupEn, rxPullupEn;
	logic serialIrq, rxWakeReq, syncEnable;
	logic [2:0] syncSubmode;
	int errorCnt, samplesChecked;

	uwm_uart #(.RX_DEPTH(2)) dut (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rxIn(rxIn), .txOut(txOut), .txOe(txOe),
		.gpioTxPullup(gpioTxPullup), .gpioRxPullup(gpioRxPullup), .txPullupEn(txPullupEn),
		.rxPullupEn(rxPullupEn), .serialIrq(serialIrq), .rxWakeReq(rxWakeReq),
		.syncSubmode(syncSubmode), .syncEnable(syncEnable));
	uwm_serial_peer #(.BIT_CLKS(BIT)) peer (.ref_clk(ref_clk), .txLine(txOut), .rxLine(rxIn));

	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic conclude();
		if (errorCnt == 0 && samplesChecked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		samplesChecked++;
		if (got !== exp) begin
			errorCnt++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Leading edge wait keeps back-to-back calls from driving psel twice in one step
	task automatic apb(input logic [ADDR_W-1:0] a, input logic wr, input logic [7:0] d,
		output logic [31:0] q);
		int i;
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= wr;
		pwdata <= {24'h000000, d};
		@(posedge ref_clk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge ref_clk);
			if (pready === 1'b1) break;
		end
		q = prdata;
		lastErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			errorCnt++;
			conclude();
		end
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		logic [31:0] q;
		apb(a, 1'b1, d, q);
	endtask

	task automatic rdChk(input string nm, input logic [ADDR_W-1:0] a, input logic [7:0] exp);
		logic [31:0] q;
		apb(a, 1'b0, 8'h00, q);
		chk(nm, {24'h000000, exp}, q);
	endtask

	function automatic logic [11:0] mkFrame(input logic [8:0] d, input logic nine,
		input logic parEn, input logic odd, input logic two, output int n);
		logic [11:0] f;
		int i;
		f = '1;
		n = 0;
		for (i = 0; i < (nine ? 9 : 8); i++) begin
			f[n] = d[i];
			n++;
		end
		if (parEn) begin
			f[n] = ^(nine ? d : {1'b0, d[7:0]}) ^ odd;
			n++;
		end
		n = n + (two ? 2 : 1);
		return f;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	task automatic tReset();
		rdChk("modeReg", ADDR_MODE, MODE_RESET);
		chk("submodeOut", 32'h00000007, {29'h0, syncSubmode});
		wr(ADDR_CTL2, 8'hc0);
		rdChk("ctl2Hidden", ADDR_CTL2, 8'h00);
		rdChk("unmapped", 8'h18, 8'h00);
		chk("slverr", 32'h00000001, {31'h0, lastErr});
	endtask

	task automatic tPins();
		wr(ADDR_MODE, 8'h12);
		@(negedge ref_clk);
		chk("syncEn", 32'h0, {31'h0, syncEnable});
		chk("submodeOut", 32'h0, {29'h0, syncSubmode});
		rdChk("status", ADDR_STAT, STAT_RESET);
		wr(ADDR_CTL1, 8'h80);
		wr(ADDR_CTL2, 8'h20);
		@(negedge ref_clk);
		chk("txOeOff", 32'h0, {31'h0, txOe});
		chk("txPullOff", 32'h1, {31'h0, txPullupEn});
		chk("rxPullOff", 32'h0, {31'h0, rxPullupEn});
		wr(ADDR_CTL2, 8'he4);
		gpioRxPullup <= 1'b1;
		wr(ADDR_BAUD, 8'h00);
		@(negedge ref_clk);
		chk("txOeOn", 32'h1, {31'h0, txOe});
		chk("txPullOn", 32'h0, {31'h0, txPullupEn});
		chk("rxPull", 32'h1, {31'h0, rxPullupEn});
	endtask

	task automatic tTx();
		logic [7:0] c1;
		logic [8:0] dv;
		logic [11:0] exp, got;
		int k, n;
		for (k = 0; k < 2; k++) begin
			c1 = k ? 8'hf9 : 8'h80;
			dv = k ? 9'h13c : 9'h0a5;
			wr(ADDR_CTL1, c1);
			wr(ADDR_DATA, dv[7:0]);
			exp = mkFrame(dv, c1[6], c1[5], c1[4], c1[3], n);
			peer.recvFrame(n, got);
			if (peer.timedOut) begin
				errorCnt++;
				conclude();
			end
			chk("txFrame", {20'h0, exp}, {20'h0, got});
			repeat (2 * BIT) @(posedge ref_clk);
			rdChk("txDone", ADDR_STAT, 8'h0b);
		end
		wr(ADDR_CTL1, 8'h80);
	endtask

	task automatic sendChar(input logic [11:0] f, input int n);
		peer.sendFrame(f, n);
		repeat (BIT) @(posedge ref_clk);
	endtask

	task automatic tRx();
		logic [11:0] f;
		int n;
		wr(ADDR_CTL2, 8'hec);
		@(negedge ref_clk);
		chk("wakeIdle", 32'h0, {31'h0, rxWakeReq});
		@(posedge ref_clk);
		// Frame built first so its length is known before the call
		f = mkFrame(9'h05a, 1'b0, 1'b0, 1'b0, 1'b0, n);
		fork
			sendChar(f, n);
			begin
				repeat (4) @(posedge ref_clk);
				chk("wakeReq", 32'h1, {31'h0, rxWakeReq});
			end
		join
		f = mkFrame(9'h0c3, 1'b0, 1'b0, 1'b0, 1'b0, n);
		sendChar(f, n);
		f = mkFrame(9'h00f, 1'b0, 1'b0, 1'b0, 1'b0, n);
		sendChar(f, n);
		@(negedge ref_clk);
		chk("irqOn", 32'h1, {31'h0, serialIrq});
		rdChk("overrun", ADDR_STAT, 8'h1f);
		rdChk("rxFirst", ADDR_DATA, 8'h5a);
		rdChk("rxSecond", ADDR_DATA, 8'hc3);
		rdChk("cleared", ADDR_STAT, 8'h0b);
		@(negedge ref_clk);
		chk("irqOff", 32'h0, {31'h0, serialIrq});
		// Even parity, parity bit flipped on the wire
		wr(ADDR_CTL1, 8'ha0);
		f = mkFrame(9'h001, 1'b0, 1'b1, 1'b0, 1'b0, n);
		f[8] = ~f[8];
		sendChar(f, n);
		rdChk("parityErr", ADDR_STAT, 8'h8f);
		rdChk("rxPar", ADDR_DATA, 8'h01);
		f = mkFrame(9'h077, 1'b0, 1'b1, 1'b0, 1'b0, n);
		sendChar(f, n);
		wr(ADDR_CTL1, 8'h00);
		rdChk("disStat", ADDR_STAT, 8'h0b);
		rdChk("disCtl2", ADDR_CTL2, 8'h2c);
		@(negedge ref_clk);
		chk("disTxOe", 32'h0, {31'h0, txOe});
	endtask

	// Nine-bit frames with address detect: ninth bit zero is skipped
	task automatic tNine();
		logic [11:0] f;
		int n;
		wr(ADDR_CTL1, 8'hc0);
		wr(ADDR_CTL2, 8'h74);
		f = mkFrame(9'h055, 1'b1, 1'b0, 1'b0, 1'b0, n);
		sendChar(f, n);
		rdChk("addrSkip", ADDR_STAT, 8'h0b);
		f = mkFrame(9'h1a6, 1'b1, 1'b0, 1'b0, 1'b0, n);
		sendChar(f, n);
		rdChk("addrStat", ADDR_STAT, 8'h0f);
		rdChk("rxNinth", ADDR_CTL1, 8'hc2);
		rdChk("addrData", ADDR_DATA, 8'ha6);
		// Stop bit held low on the wire
		f = mkFrame(9'h101, 1'b1, 1'b0, 1'b0, 1'b0, n);
		f[9] = 1'b0;
		sendChar(f, n);
		rdChk("frameErr", ADDR_STAT, 8'h2f);
		rdChk("frameData", ADDR_DATA, 8'h01);
		rdChk("frameClr", ADDR_STAT, 8'h0b);
	endtask

	initial begin
		reset_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		gpioTxPullup = 1'b1;
		gpioRxPullup = 1'b0;
		errorCnt = 0;
		samplesChecked = 0;
		repeat (8) @(posedge ref_clk);
		reset_n <= 1'b1;
		tReset();
		tPins();
		tTx();
		tRx();
		tNine();
		conclude();
	end
endmodule
`default_nettype wire
